// ==== design/qar_pkg.sv ====
/*
 * constants and types shared by the quad converter readout block.
 * assumes a single 100 MHz system clock and no register bus.
 */
package qar_pkg;
    // ------------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------------
    localparam int NUM_CH      = 4;
    localparam int RES_BITS    = 16;
    localparam int CNT_W       = 5;
    localparam logic [CNT_W-1:0] SHIFT_EDGES = 5'h10;
    localparam logic [CNT_W-1:0] CNT_ZERO    = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE     = 5'h01;
    localparam int CLK_MHZ     = 100;
    // conversion time in ns and its cycle count (longest, rounded down)
    localparam int CONV_NS     = 300;
    localparam int CONV_CYC    = (CONV_NS * CLK_MHZ) / 1000;
    localparam int CONV_W      = 8;
    localparam logic [CONV_W-1:0] CONV_CYCLES = CONV_W'(CONV_CYC);
    localparam logic [CONV_W-1:0] CONV_ZERO   = 8'h00;
    localparam logic [CONV_W-1:0] CONV_ONE    = 8'h01;
    localparam logic [RES_BITS-1:0] RES_ZERO  = 16'h0000;
    localparam logic [RES_BITS-1:0] RES_ONE   = 16'h0001;

    // ------------------------------------------------------------------
    // signalling select coding
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        QAR_IO_CMOS,
        QAR_IO_LVDS,
        QAR_IO_LP_LVDS
    } qar_io_mode_t;

    typedef enum logic [1:0] {
        QAR_ACQUIRE,
        QAR_CONVERT,
        QAR_READOUT
    } qar_state_t;
endpackage

// ==== design/qar_buf2.sv ====
/*
 * two-entry valid/ready buffer on the result path.
 * assumes both sides on clock_i; synchronous active-low reset.
 */
`timescale 1ns/1ps
module qar_buf2
    import qar_pkg::*;
#(
    parameter int WIDTH = 64,
    parameter int DEPTH = 2
) (
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic             wr_ptr;
    logic             rd_ptr;
    logic [1:0]       count;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ptr];

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + 2'(push) - 2'(pop);
        end
    end

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule

// ==== design/qar_readout.sv ====
/*
 * digital control and serial readout of a four-channel converter.
 * assumes strobe, shift clock and mode pins arrive asynchronously
 * and are sampled by clock_i; results come from the analog core as
 * a valid/ready word of four 16-bit two's complement codes.
 */
`timescale 1ns/1ps
// Summary of operation
// - strobe high keeps all channels acquiring
// - strobe low starts conversion, results then available
// - rate low: shift on falling edges only
// - rate high: shift on both edges
// - msb first, sixteen edges per result
// - cmos: four single-ended lanes in parallel
// - lvds: channels on pairs a to d
// - echo clock copies shift clock, delayed
// - disable high stops echo clock
// - select low cmos, high lvds, float low-power
// - strobe behaviour independent of signalling select
// - ref buffer enable low turns buffers off
// - results are two's complement
module qar_readout
    import qar_pkg::*;
(
    input  wire logic                 clock_i,
    input  wire logic                 resetn_i,
    input  wire logic                 sample_convert_strobe_i,
    input  wire logic                 shift_clock_i,
    input  wire logic                 rate_select_i,
    input  wire logic                 echo_clock_disable_i,
    input  wire logic                 io_select_high_i,
    input  wire logic                 io_select_float_i,
    input  wire logic                 ref_buffer_enable_i,
    input  wire logic [RES_BITS-1:0]  core_result_i [NUM_CH],
    input  wire logic                 core_valid_i,
    output logic                      core_ready_o,
    output logic                      acquire_o,
    output logic                      convert_start_o,
    output logic [NUM_CH-1:0]         ref_buffer_on_o,
    output qar_io_mode_t              io_mode_o,
    output logic [NUM_CH-1:0]         cmos_lane_o,
    output logic [NUM_CH-1:0]         lane_pair_p_o,
    output logic [NUM_CH-1:0]         lane_pair_n_o,
    output logic                      lvds_low_power_o,
    output logic                      echo_clock_out_o,
    output logic                      echo_clock_out_n_o,
    output logic                      results_ready_o
);
    import qar_pkg::*;

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [6:0] meta;
    logic [6:0] sync;
    logic       strobe_s;
    logic       sck_s;
    logic       rate_s;
    logic       echo_dis_s;
    logic       sel_hi_s;
    logic       sel_fl_s;
    logic       refen_s;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            meta <= 7'h7F;
            sync <= 7'h7F;
        end else begin
            meta <= {sample_convert_strobe_i, shift_clock_i, rate_select_i,
                     echo_clock_disable_i, io_select_high_i,
                     io_select_float_i, ref_buffer_enable_i};
            sync <= meta;
        end
    end

    assign strobe_s   = sync[6];
    assign sck_s      = sync[5];
    assign rate_s     = sync[4];
    assign echo_dis_s = sync[3];
    assign sel_hi_s   = sync[2];
    assign sel_fl_s   = sync[1];
    assign refen_s    = sync[0];

    // ------------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------------
    logic strobe_d;
    logic sck_d;
    logic strobe_fall;
    logic sck_rise;
    logic sck_fall;
    logic shift_edge;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            // both match the synchroniser reset so no false edge follows
            strobe_d <= 1'b1;
            sck_d    <= 1'b1;
        end else begin
            strobe_d <= strobe_s;
            sck_d    <= sck_s;
        end
    end

    assign strobe_fall = strobe_d && !strobe_s;
    assign sck_rise    = !sck_d && sck_s;
    assign sck_fall    = sck_d && !sck_s;
    // falling only in single rate, both edges in double rate
    assign shift_edge  = rate_s ? (sck_rise || sck_fall)
                                : sck_fall;

    // ------------------------------------------------------------------
    // mode decode, static pins
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            io_mode_o       <= QAR_IO_CMOS;
            ref_buffer_on_o <= '1;
        end else begin
            // float detection is a pin-level matter outside this logic
            if (sel_fl_s) begin
                io_mode_o <= QAR_IO_LP_LVDS;
            end else if (sel_hi_s) begin
                io_mode_o <= QAR_IO_LVDS;
            end else begin
                io_mode_o <= QAR_IO_CMOS;
            end
            ref_buffer_on_o <= {NUM_CH{refen_s}};
        end
    end

    assign lvds_low_power_o = (io_mode_o == QAR_IO_LP_LVDS);

    // ------------------------------------------------------------------
    // phase sequencer
    // ------------------------------------------------------------------
    qar_state_t        state;
    logic [CONV_W-1:0] conv_cnt;
    logic              res_valid;

    // strobe handling never looks at io_mode_o
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            state    <= QAR_ACQUIRE;
            conv_cnt <= CONV_ZERO;
        end else begin
            case (state)
                QAR_ACQUIRE: begin
                    if (strobe_fall) begin
                        state    <= QAR_CONVERT;
                        conv_cnt <= CONV_CYCLES;
                    end
                end
                QAR_CONVERT: begin
                    if (conv_cnt > CONV_ONE) begin
                        conv_cnt <= conv_cnt - CONV_ONE;
                    end else if (res_valid) begin
                        state <= QAR_READOUT;
                    end
                end
                QAR_READOUT: begin
                    if (strobe_s) begin
                        state <= QAR_ACQUIRE;
                    end
                end
                default: begin
                    state <= QAR_ACQUIRE;
                end
            endcase
        end
    end

    assign acquire_o = (state == QAR_ACQUIRE) && strobe_s;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            convert_start_o <= 1'b0;
        end else begin
            convert_start_o <= (state == QAR_ACQUIRE) && strobe_fall;
        end
    end

    // ------------------------------------------------------------------
    // result buffer: a stalled load keeps the word, none is lost
    // ------------------------------------------------------------------
    localparam int WORD_W = NUM_CH * RES_BITS;
    logic [WORD_W-1:0] core_word;
    logic [WORD_W-1:0] res_word;
    logic              res_take;

    assign res_take = (state == QAR_CONVERT) && (conv_cnt <= CONV_ONE);

    qar_buf2 #(
        .WIDTH (WORD_W),
        .DEPTH (2)
    ) u_buf (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .in_data_i   (core_word),
        .in_valid_i  (core_valid_i),
        .in_ready_o  (core_ready_o),
        .out_data_o  (res_word),
        .out_valid_o (res_valid),
        .out_ready_i (res_take)
    );

    // ------------------------------------------------------------------
    // per-channel shift registers
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] edge_cnt;

    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
            logic [RES_BITS-1:0] shreg;

            assign core_word[ch*RES_BITS +: RES_BITS] = core_result_i[ch];

            // codes pass untouched: the core delivers two's complement
            always_ff @(posedge clock_i) begin
                if (!resetn_i) begin
                    shreg <= RES_ZERO;
                end else if (res_take && res_valid) begin
                    shreg <= res_word[ch*RES_BITS +: RES_BITS];
                end else if (state == QAR_READOUT && shift_edge
                             && edge_cnt != CNT_ZERO) begin
                    shreg <= {shreg[RES_BITS-2:0], 1'b0};
                end
            end

            // msb is always on the lane; each edge brings the next bit
            always_ff @(posedge clock_i) begin
                if (!resetn_i) begin
                    cmos_lane_o[ch]   <= 1'b0;
                    lane_pair_p_o[ch] <= 1'b0;
                    lane_pair_n_o[ch] <= 1'b1;
                end else begin
                    cmos_lane_o[ch] <= (io_mode_o == QAR_IO_CMOS)
                                       && shreg[RES_BITS-1];
                    lane_pair_p_o[ch] <= (io_mode_o != QAR_IO_CMOS)
                                         && shreg[RES_BITS-1];
                    lane_pair_n_o[ch] <= !((io_mode_o != QAR_IO_CMOS)
                                         && shreg[RES_BITS-1]);
                end
            end
        end
    endgenerate

    // sixteen edges read one result in either rate
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            edge_cnt <= CNT_ZERO;
        end else if (res_take && res_valid) begin
            edge_cnt <= SHIFT_EDGES;
        end else if (state == QAR_READOUT && shift_edge
                     && edge_cnt != CNT_ZERO) begin
            edge_cnt <= edge_cnt - CNT_ONE;
        end
    end

    assign results_ready_o = (state == QAR_READOUT)
                             && (edge_cnt != CNT_ZERO);

    // ------------------------------------------------------------------
    // echo clock: delayed copy of the shift clock
    // ------------------------------------------------------------------
    // the delay is the synchroniser plus one flop; the lanes change one clock later,
    // so a host must let data settle after it before capturing (host side duty)
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            echo_clock_out_o   <= 1'b0;
            echo_clock_out_n_o <= 1'b1;
        end else if (echo_dis_s) begin
            echo_clock_out_o   <= 1'b0;
            echo_clock_out_n_o <= (io_mode_o != QAR_IO_CMOS);
        end else begin
            echo_clock_out_o   <= sck_s;
            echo_clock_out_n_o <= !sck_s;
        end
    end
endmodule

// ==== verification/qar_readout_asserts.sv ====
/*
 * port checks for the quad readout block.
 * assumes one clock domain, synchronous active-low reset.
 */
`timescale 1ns/1ps
module qar_readout_asserts
    import qar_pkg::*;
(
    input wire logic         clock_i,
    input wire logic         resetn_i,
    input wire logic         sample_convert_strobe_i,
    input wire logic         shift_clock_i,
    input wire logic         echo_clock_disable_i,
    input wire logic         io_select_high_i,
    input wire logic         io_select_float_i,
    input wire logic         ref_buffer_enable_i,
    input wire logic         acquire_o,
    input wire logic         convert_start_o,
    input wire logic [3:0]   ref_buffer_on_o,
    input wire qar_io_mode_t io_mode_o,
    input wire logic [3:0]   cmos_lane_o,
    input wire logic [3:0]   lane_pair_p_o,
    input wire logic [3:0]   lane_pair_n_o,
    input wire logic         echo_clock_out_o,
    input wire logic         results_ready_o
);
    // ----------
    // properties
    // ----------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    qar_io_mode_t want;
    assign want = io_select_float_i ? QAR_IO_LP_LVDS :
                  io_select_high_i ? QAR_IO_LVDS : QAR_IO_CMOS;
    acq_idle_a: assert property (acquire_o |-> !results_ready_o)
        else $error("ready while acquiring");
    kick_time_a: assert property ($fell(sample_convert_strobe_i)
        && acquire_o |-> ##[2:5] convert_start_o) else $error("no start");
    kick_pulse_a: assert property (convert_start_o |=> !convert_start_o)
        else $error("start too long");
    load_time_a: assert property (convert_start_o
        |-> ##[28:34] results_ready_o) else $error("no load");
    ref_follow_a: assert property ($stable(ref_buffer_enable_i) [*6]
        |-> ref_buffer_on_o == {4{ref_buffer_enable_i}})
        else $error("ref buffers wrong");
    mode_pick_a: assert property ($stable(want) [*6]
        |-> io_mode_o == want) else $error("mode wrong");
    cmos_quiet_a: assert property ($stable(io_mode_o)
        && io_mode_o == QAR_IO_CMOS
        |-> lane_pair_p_o == 4'h0 && lane_pair_n_o == 4'hF)
        else $error("pairs active in cmos");
    pair_comp_a: assert property ($stable(io_mode_o)
        && io_mode_o != QAR_IO_CMOS
        |-> lane_pair_n_o == ~lane_pair_p_o && cmos_lane_o == 4'h0)
        else $error("pairs not complementary");
    echo_off_a: assert property (echo_clock_disable_i [*6]
        |-> !echo_clock_out_o) else $error("echo not off");
    echo_copy_a: assert property (!echo_clock_disable_i [*6]
        |-> echo_clock_out_o == $past(shift_clock_i, 3))
        else $error("echo not a copy");
    cover property (convert_start_o);
    cover property ($rose(results_ready_o));
    cover property (io_mode_o == QAR_IO_LP_LVDS && results_ready_o);
endmodule
bind qar_readout qar_readout_asserts u_chk (.*);

// ==== verification/qar_host_model.sv ====
/*
 * host model: makes the shift clock, captures the four lanes.
 * assumes results are ready when frame is called.
 */
`timescale 1ns/1ps
module qar_host_model
    import qar_pkg::*;
(
    input  wire logic       rate_select_i,
    input  wire logic [3:0] lane_i,
    input  wire logic       echo_i,
    output logic            shift_clock_o
);
    // ----------
    // capture
    // ----------
    logic [RES_BITS-1:0] got [NUM_CH];
    initial shift_clock_o = 1'h1;
    // lanes move with the echo, so settle is timed from it, not sck
    task automatic edge_to(input logic lvl);
        shift_clock_o = lvl;
        wait (echo_i === lvl);
    endtask
    // clock stands high between frames
    task automatic frame();
        for (int e = 0; e < RES_BITS; e++) begin
            #62.5;
            for (int c = 0; c < NUM_CH; c++) got[c][15-e] = lane_i[c];
            edge_to(rate_select_i ? ~shift_clock_o : 1'h0);
            if (!rate_select_i) begin
                #62.5;
                edge_to(1'h1);
            end
        end
    endtask
endmodule

// ==== verification/quad_adc_serial_readout_tb.sv ====
/*
 * self-checking bench for the quad readout block.
 * assumes the host model and the bound checker.
 */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin \
    bad_count++; $display("BAD %s exp %0h got %0h", nm, e, s); end end
module quad_adc_serial_readout_tb;
    import qar_pkg::*;
    logic                clock_i, resetn_i, sample_convert_strobe_i;
    logic                shift_clock_i, rate_select_i, echo_clock_disable_i;
    logic                io_select_high_i, io_select_float_i;
    logic                ref_buffer_enable_i, core_valid_i, core_ready_o;
    logic [RES_BITS-1:0] core_result_i [NUM_CH];
    logic                acquire_o, convert_start_o, lvds_low_power_o;
    logic [3:0]          ref_buffer_on_o, cmos_lane_o, lane;
    logic [3:0]          lane_pair_p_o, lane_pair_n_o;
    logic                echo_clock_out_o, echo_clock_out_n_o;
    logic                results_ready_o;
    qar_io_mode_t        io_mode_o;
    logic [63:0]         expq [$];
    int                  bad_count, compares, seed;
    // ----------
    // plumbing
    // ----------
    assign lane = (io_select_high_i | io_select_float_i) ?
                  lane_pair_p_o : cmos_lane_o;
    qar_readout DUT (.*);
    qar_host_model host (.rate_select_i, .lane_i(lane),
        .echo_i(echo_clock_out_o), .shift_clock_o(shift_clock_i));
    initial begin
        clock_i = 1'h0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic results();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // valid held through a stall until the buffer takes the word
    task automatic offer(input logic [63:0] w);
        @(posedge clock_i);
        for (int c = 0; c < NUM_CH; c++) core_result_i[c] <= w[16*c+:16];
        core_valid_i <= 1'h1;
        @(negedge clock_i);
        repeat (200) if (core_ready_o !== 1'h1) @(negedge clock_i);
        @(posedge clock_i);
        expq.push_back(w);
        core_valid_i <= 1'h0;
    endtask
    task automatic run(input int i);
        logic [63:0] w;
        logic        en;
        en = $random(seed);
        @(posedge clock_i);
        rate_select_i <= (i >= 3);
        io_select_high_i <= (i % 3 == 1);
        io_select_float_i <= (i % 3 == 2);
        ref_buffer_enable_i <= en;
        repeat (8) @(posedge clock_i);
        @(negedge clock_i);
        `CHK("mode", qar_io_mode_t'(i % 3), io_mode_o)
        `CHK("lowpow", i % 3 == 2, lvds_low_power_o)
        `CHK("refbuf", {4{en}}, ref_buffer_on_o)
        `CHK("acquire", 1'h1, acquire_o)
        @(posedge clock_i);
        sample_convert_strobe_i <= 1'h0;
        @(negedge clock_i);
        repeat (8) if (convert_start_o !== 1'h1) @(negedge clock_i);
        `CHK("start", 1'h1, convert_start_o)
        repeat (60) if (results_ready_o !== 1'h1) @(negedge clock_i);
        `CHK("ready", 1'h1, results_ready_o)
        host.frame();
        w = expq.pop_front();
        for (int c = 0; c < NUM_CH; c++)
            `CHK("lane", w[16*c+:16], host.got[c])
        repeat (4) @(negedge clock_i);
        `CHK("done", 1'h0, results_ready_o)
        @(posedge clock_i);
        sample_convert_strobe_i <= 1'h1;
        repeat (6) @(posedge clock_i);
        $display("test %0d done", i);
    endtask
    initial begin
        seed = 7;
        bad_count = 0;
        compares = 0;
        resetn_i = 1'h0;
        sample_convert_strobe_i = 1'h1;
        rate_select_i = 1'h0;
        echo_clock_disable_i = 1'h0;
        io_select_high_i = 1'h0;
        io_select_float_i = 1'h0;
        ref_buffer_enable_i = 1'h1;
        core_valid_i = 1'h0;
        for (int c = 0; c < NUM_CH; c++) core_result_i[c] = '0;
        repeat (5) @(posedge clock_i);
        resetn_i <= 1'h1;
        repeat (4) @(posedge clock_i);
        echo_clock_disable_i <= 1'h1;
        repeat (8) @(posedge clock_i);
        @(negedge clock_i);
        `CHK("echo_off", 1'h0, echo_clock_out_o)
        `CHK("echo_n_off", 1'h0, echo_clock_out_n_o)
        @(posedge clock_i);
        echo_clock_disable_i <= 1'h0;
        repeat (8) @(posedge clock_i);
        @(negedge clock_i);
        `CHK("echo_idle", 1'h1, echo_clock_out_o)
        $display("test echo done");
        offer(64'h8000_7FFF_FFFF_0001);
        offer({$random(seed), $random(seed)});
        @(negedge clock_i);
        `CHK("full", 1'h0, core_ready_o)
        for (int i = 0; i < 6; i++)
            fork
                offer({$random(seed), $random(seed)});
                run(i);
            join
        results();
    end
    // six frames need about 20 us; allow ten times that
    initial begin
        #200000;
        bad_count++;
        results();
    end
endmodule
